//--- inc/dce_pkg.sv
// Purpose: shared constants and types of the debug command engine
// Assumes: byte-wide host link, 16-bit memory addresses
// Notes: command codes, register layouts and fill values live here
package dce_pkg;

    typedef logic [7:0] dce_byte_t;
    typedef logic [15:0] dce_addr_t;

    // host command codes
    localparam dce_byte_t CMD_RD_STAT = 8'h02;
    localparam dce_byte_t CMD_WR_CTL = 8'h04;
    localparam dce_byte_t CMD_RD_CTL = 8'h05;
    localparam dce_byte_t CMD_RD_REG = 8'h09;
    localparam dce_byte_t CMD_WR_PM = 8'h0A;
    localparam dce_byte_t CMD_RD_PM = 8'h0B;
    localparam dce_byte_t CMD_WR_DM = 8'h0C;
    localparam dce_byte_t CMD_RD_DM = 8'h0D;
    localparam dce_byte_t CMD_CRC = 8'h0E;
    localparam dce_byte_t CMD_STEP = 8'h10;
    localparam dce_byte_t CMD_STUFF = 8'h11;
    localparam dce_byte_t CMD_EXEC = 8'h12;

    // debugger_control layout
    localparam int CTL_DBG_BIT = 7;
    localparam int CTL_BPEN_BIT = 6;
    localparam int CTL_ACK_BIT = 5;
    localparam int CTL_RST_BIT = 0;
    localparam dce_byte_t CTL_WMASK = 8'hE1;
    localparam dce_byte_t CTL_RESET = 8'h00;

    // debugger_status layout
    localparam int STAT_DBG_BIT = 7;
    localparam int STAT_HALT_BIT = 6;
    localparam int STAT_RPI_BIT = 5;
    localparam dce_byte_t STAT_RESET = 8'h00;

    // fillers and sizes
    localparam dce_byte_t FILL_BYTE = 8'hFF;
    localparam dce_byte_t ACK_BYTE = 8'hFF;
    localparam logic [16:0] MEM_FULL_SIZE = 17'h10000;
    localparam logic [16:0] REG_FULL_SIZE = 17'h00100;
    localparam logic [3:0] REG_ADDR_TOP = 4'h0;

    // program memory check
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_BLOCKED = 16'hFFFF;

endpackage : dce_pkg

//--- inc/dce_byte_if.sv
// Purpose: byte stream with valid/ready between engine parts
// Assumes: transfer when valid and ready are both high at a clock edge
// Notes: src drives valid and data, snk drives ready
`timescale 1ns/10ps
interface dce_byte_if;
    logic valid;
    logic ready;
    dce_pkg::dce_byte_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dce_byte_if

//--- design/dce_skid_buf.sv
// Purpose: two-entry buffer on the reply path to the host
// Assumes: same clock on both sides
// Notes: all outputs come from flip-flops; ready drops only when both entries hold
`timescale 1ns/10ps
module dce_skid_buf #(
    parameter int W = 8
) (
    // clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // filling side
    dce_byte_if.snk in_s,
    // draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import dce_pkg::*;

    typedef struct packed {
        logic head_vld;
        logic tail_vld;
        logic [W-1:0] head;
        logic [W-1:0] tail;
    } dce_buf_s;

    dce_buf_s r_reg;
    dce_buf_s r_next;
    logic push;
    logic pop;

    assign push = in_s.valid && !r_reg.tail_vld;
    assign pop = r_reg.head_vld && out_ready;

    always_comb begin
        r_next = r_reg;
        if (pop) begin
            r_next.head_vld = r_reg.tail_vld;
            r_next.head = r_reg.tail;
            r_next.tail_vld = 1'b0;
        end
        if (push) begin
            if (!r_next.head_vld) begin
                r_next.head_vld = 1'b1;
                r_next.head = in_s.data;
            end else begin
                r_next.tail_vld = 1'b1;
                r_next.tail = in_s.data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign in_s.ready = !r_reg.tail_vld;
    assign out_valid = r_reg.head_vld;
    assign out_data = r_reg.head;

endmodule : dce_skid_buf

//--- design/dce_crc16.sv
// Purpose: byte-serial 16-bit check over the program memory image
// Assumes: one byte per clock at most, msb of each byte first
// Notes: init reloads the start value and wins over a byte in the same cycle
`timescale 1ns/10ps
module dce_crc16 (
    // clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic init,
    // byte feed
    dce_byte_if.snk feed,
    // result
    output logic [15:0] crc
);
    import dce_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } dce_crc_s;

    dce_crc_s r_reg;
    dce_crc_s r_next;

    function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input dce_byte_t d);
        logic [15:0] c;
        logic fb;
        c = c_in;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc_byte

    always_comb begin
        r_next = r_reg;
        if (init) begin
            r_next.crc = CRC_INIT;
        end else if (feed.valid) begin
            r_next.crc = crc_byte(r_reg.crc, feed.data);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg.crc <= CRC_INIT;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign feed.ready = 1'b1;
    assign crc = r_reg.crc;

endmodule : dce_crc16

//--- design/dce_engine.sv
// Purpose: device-side command engine of the on-chip debugger
// Assumes: host bytes arrive already decoded from the debug pin, same clock
// Notes: memories answer one cycle after the read enable output is high
`timescale 1ns/10ps
module dce_engine #(
    parameter int PMEM_BYTES = 65536
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // bytes from host
    input wire logic rx_valid,
    input wire dce_pkg::dce_byte_t rx_data,
    output logic rx_ready,
    // bytes to host
    output logic tx_valid,
    output dce_pkg::dce_byte_t tx_data,
    input wire logic tx_ready,
    // memory ports
    output dce_pkg::dce_addr_t mem_addr,
    output dce_pkg::dce_byte_t mem_wr_data,
    output logic pm_rd_en,
    output logic pm_wr_en,
    output logic dm_rd_en,
    output logic dm_wr_en,
    output logic rf_rd_en,
    input wire dce_pkg::dce_byte_t pm_rd_data,
    input wire dce_pkg::dce_byte_t dm_rd_data,
    input wire dce_pkg::dce_byte_t rf_rd_data,
    // system status
    input wire logic flash_unlocked,
    input wire logic read_protect_option,
    input wire logic cpu_halt_mode,
    input wire logic bp_decoded,
    input wire logic sys_reset_done,
    // cpu control
    output logic cpu_debug_halt,
    output logic breakpoint_enable,
    output logic sys_reset_req,
    output logic step_req,
    output logic stuff_req,
    output logic exec_valid,
    output logic exec_first,
    output dce_pkg::dce_byte_t exec_byte,
    input wire logic [2:0] exec_len
);
    import dce_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_SIZE_HI,
        ST_SIZE_LO,
        ST_WDATA,
        ST_RD_REQ,
        ST_RD_WAIT,
        ST_RD_CAP,
        ST_RD_SEND,
        ST_CTL_DATA,
        ST_STUFF_OP,
        ST_EXEC_BYTE,
        ST_EXEC_LEN,
        ST_CRC_RUN,
        ST_CRC_TAIL,
        ST_TX_FIRST,
        ST_TX_LAST
    } dce_state_e;

    typedef struct packed {
        dce_state_e st;
        dce_byte_t cmd;
        dce_addr_t addr;
        logic [16:0] rem;
        dce_byte_t ctl;
        logic tx_vld;
        dce_byte_t tx_dat;
        dce_byte_t tx2;
        logic rx_rdy;
        logic pm_rd_en;
        logic dm_rd_en;
        logic rf_rd_en;
        logic pm_wr_en;
        logic dm_wr_en;
        dce_byte_t wr_dat;
        logic crc_v1;
        logic crc_init;
        logic ack_pend;
        logic step_req;
        logic stuff_req;
        logic exec_vld;
        logic exec_first;
        dce_byte_t exec_dat;
    } dce_eng_s;

    dce_eng_s r_reg;
    dce_eng_s r_next;

    dce_byte_if tx_if ();
    dce_byte_if crc_if ();

    logic [15:0] crc_val;
    logic rx_hit;
    logic tx_hit;
    logic in_dbg;
    logic prot;
    logic [16:0] size_in;
    dce_byte_t stat_byte;
    dce_byte_t rd_byte;

    assign rx_hit = r_reg.rx_rdy && rx_valid;
    assign tx_hit = r_reg.tx_vld && tx_if.ready;
    assign in_dbg = r_reg.ctl[CTL_DBG_BIT];
    assign prot = read_protect_option;

    always_comb begin
        stat_byte = STAT_RESET;
        stat_byte[STAT_DBG_BIT] = in_dbg;
        stat_byte[STAT_HALT_BIT] = cpu_halt_mode;
        stat_byte[STAT_RPI_BIT] = !prot;
    end

    always_comb begin
        case (r_reg.cmd)
            CMD_RD_DM: rd_byte = dm_rd_data;
            CMD_RD_REG: rd_byte = rf_rd_data;
            default: rd_byte = pm_rd_data;
        endcase
    end

    // size zero means the full range of the command
    always_comb begin
        if (r_reg.cmd == CMD_RD_REG) begin
            size_in = (rx_data == 8'h00) ? REG_FULL_SIZE : {9'h000, rx_data};
        end else begin
            size_in = ({r_reg.rem[15:8], rx_data} == 16'h0000) ? MEM_FULL_SIZE : {1'b0, r_reg.rem[15:8], rx_data};
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.pm_rd_en = 1'b0;
        r_next.dm_rd_en = 1'b0;
        r_next.rf_rd_en = 1'b0;
        r_next.pm_wr_en = 1'b0;
        r_next.dm_wr_en = 1'b0;
        r_next.crc_init = 1'b0;
        r_next.step_req = 1'b0;
        r_next.stuff_req = 1'b0;
        r_next.exec_vld = 1'b0;
        r_next.crc_v1 = r_reg.pm_rd_en && (r_reg.cmd == CMD_CRC);
        if (tx_hit) begin
            r_next.tx_vld = 1'b0;
        end
        // advance after each write or check-sum fetch
        if (r_reg.pm_wr_en || r_reg.dm_wr_en || (r_reg.pm_rd_en && r_reg.cmd == CMD_CRC)) begin
            r_next.addr = r_reg.addr + 16'h0001;
        end
        if (sys_reset_done) begin
            r_next.ctl[CTL_RST_BIT] = 1'b0;
        end
        case (r_reg.st)
            ST_IDLE: begin
                if (r_reg.ack_pend) begin
                    r_next.ack_pend = 1'b0;
                    r_next.tx_vld = 1'b1;
                    r_next.tx_dat = ACK_BYTE;
                    r_next.st = ST_TX_LAST;
                end else if (rx_hit) begin
                    r_next.cmd = rx_data;
                    case (rx_data)
                        CMD_RD_STAT: begin
                            r_next.tx_vld = 1'b1;
                            r_next.tx_dat = stat_byte;
                            r_next.st = ST_TX_LAST;
                        end
                        CMD_WR_CTL: begin
                            r_next.st = ST_CTL_DATA;
                        end
                        CMD_RD_CTL: begin
                            r_next.tx_vld = 1'b1;
                            r_next.tx_dat = r_reg.ctl & CTL_WMASK;
                            r_next.st = ST_TX_LAST;
                        end
                        CMD_RD_REG, CMD_WR_PM, CMD_RD_PM, CMD_WR_DM, CMD_RD_DM: begin
                            r_next.st = ST_ADDR_HI;
                        end
                        CMD_CRC: begin
                            if (in_dbg) begin
                                r_next.crc_init = 1'b1;
                                r_next.addr = 16'h0000;
                                r_next.rem = 17'(PMEM_BYTES);
                                r_next.st = ST_CRC_RUN;
                            end else begin
                                r_next.tx_vld = 1'b1;
                                r_next.tx_dat = CRC_BLOCKED[15:8];
                                r_next.tx2 = CRC_BLOCKED[7:0];
                                r_next.st = ST_TX_FIRST;
                            end
                        end
                        CMD_STEP: begin
                            r_next.step_req = in_dbg && !prot;
                        end
                        CMD_STUFF: begin
                            r_next.st = ST_STUFF_OP;
                        end
                        CMD_EXEC: begin
                            r_next.exec_first = 1'b1;
                            r_next.st = ST_EXEC_BYTE;
                        end
                        default: begin
                            r_next.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_ADDR_HI: begin
                if (rx_hit) begin
                    r_next.addr[15:8] = rx_data;
                    r_next.st = ST_ADDR_LO;
                end
            end
            ST_ADDR_LO: begin
                if (rx_hit) begin
                    r_next.addr[7:0] = rx_data;
                    if (r_reg.cmd == CMD_RD_REG) begin
                        r_next.addr[15:12] = REG_ADDR_TOP;
                        r_next.st = ST_SIZE_LO;
                    end else begin
                        r_next.st = ST_SIZE_HI;
                    end
                end
            end
            ST_SIZE_HI: begin
                if (rx_hit) begin
                    r_next.rem = {1'b0, rx_data, 8'h00};
                    r_next.st = ST_SIZE_LO;
                end
            end
            ST_SIZE_LO: begin
                if (rx_hit) begin
                    r_next.rem = size_in;
                    if (r_reg.cmd == CMD_WR_PM || r_reg.cmd == CMD_WR_DM) begin
                        r_next.st = ST_WDATA;
                    end else begin
                        r_next.st = ST_RD_REQ;
                    end
                end
            end
            ST_WDATA: begin
                if (rx_hit) begin
                    r_next.wr_dat = rx_data;
                    if (r_reg.cmd == CMD_WR_PM) begin
                        r_next.pm_wr_en = in_dbg && !prot && flash_unlocked;
                    end else begin
                        r_next.dm_wr_en = in_dbg && !prot;
                    end
                    r_next.rem = r_reg.rem - 17'h00001;
                    if (r_reg.rem == 17'h00001) begin
                        r_next.st = ST_IDLE;
                    end
                end
            end
            ST_RD_REQ: begin
                if ((r_reg.cmd == CMD_RD_DM) ? !in_dbg : (!in_dbg || prot)) begin
                    r_next.tx_vld = 1'b1;
                    r_next.tx_dat = FILL_BYTE;
                    r_next.st = ST_RD_SEND;
                end else begin
                    r_next.pm_rd_en = (r_reg.cmd == CMD_RD_PM);
                    r_next.dm_rd_en = (r_reg.cmd == CMD_RD_DM);
                    r_next.rf_rd_en = (r_reg.cmd == CMD_RD_REG);
                    r_next.st = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                r_next.st = ST_RD_CAP;
            end
            ST_RD_CAP: begin
                r_next.tx_vld = 1'b1;
                r_next.tx_dat = rd_byte;
                r_next.st = ST_RD_SEND;
            end
            ST_RD_SEND: begin
                if (tx_hit) begin
                    r_next.addr = r_reg.addr + 16'h0001;
                    r_next.rem = r_reg.rem - 17'h00001;
                    r_next.st = (r_reg.rem == 17'h00001) ? ST_IDLE : ST_RD_REQ;
                end
            end
            ST_CTL_DATA: begin
                if (rx_hit) begin
                    r_next.ctl = rx_data & CTL_WMASK;
                    r_next.ctl[CTL_DBG_BIT] = rx_data[CTL_DBG_BIT] || (prot && in_dbg);
                    r_next.st = ST_IDLE;
                end
            end
            ST_STUFF_OP: begin
                if (rx_hit) begin
                    r_next.exec_dat = rx_data;
                    r_next.stuff_req = in_dbg && !prot;
                    r_next.st = ST_IDLE;
                end
            end
            ST_EXEC_BYTE: begin
                if (rx_hit) begin
                    r_next.exec_first = 1'b0;
                    if (!in_dbg || prot) begin
                        r_next.st = ST_IDLE;
                    end else begin
                        r_next.exec_vld = 1'b1;
                        r_next.exec_dat = rx_data;
                        r_next.rem = r_reg.rem - 17'h00001;
                        if (r_reg.exec_first) begin
                            r_next.st = ST_EXEC_LEN;
                        end else if (r_reg.rem == 17'h00001) begin
                            r_next.st = ST_IDLE;
                        end
                    end
                end
            end
            ST_EXEC_LEN: begin
                // cpu sizes the instruction from the first byte on show
                r_next.rem = {14'h0000, exec_len} - 17'h00001;
                r_next.st = (exec_len <= 3'h1) ? ST_IDLE : ST_EXEC_BYTE;
            end
            ST_CRC_RUN: begin
                r_next.pm_rd_en = 1'b1;
                r_next.rem = r_reg.rem - 17'h00001;
                if (r_reg.rem == 17'h00001) begin
                    r_next.st = ST_CRC_TAIL;
                end
            end
            ST_CRC_TAIL: begin
                if (!r_reg.pm_rd_en && !r_reg.crc_v1) begin
                    r_next.tx_vld = 1'b1;
                    r_next.tx_dat = crc_val[15:8];
                    r_next.tx2 = crc_val[7:0];
                    r_next.st = ST_TX_FIRST;
                end
            end
            ST_TX_FIRST: begin
                if (tx_hit) begin
                    r_next.tx_vld = 1'b1;
                    r_next.tx_dat = r_reg.tx2;
                    r_next.st = ST_TX_LAST;
                end
            end
            ST_TX_LAST: begin
                if (tx_hit) begin
                    r_next.st = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        // breakpoint set wins over any clear in the same cycle
        if (bp_decoded && r_reg.ctl[CTL_BPEN_BIT]) begin
            r_next.ctl[CTL_DBG_BIT] = 1'b1;
            if (r_reg.ctl[CTL_ACK_BIT]) begin
                r_next.ack_pend = 1'b1;
            end
        end
        case (r_next.st)
            ST_IDLE: r_next.rx_rdy = !r_next.ack_pend;
            ST_ADDR_HI, ST_ADDR_LO, ST_SIZE_HI, ST_SIZE_LO, ST_WDATA,
            ST_CTL_DATA, ST_STUFF_OP, ST_EXEC_BYTE: r_next.rx_rdy = 1'b1;
            default: r_next.rx_rdy = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ctl <= CTL_RESET;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign tx_if.valid = r_reg.tx_vld;
    assign tx_if.data = r_reg.tx_dat;
    assign crc_if.valid = r_reg.crc_v1;
    assign crc_if.data = pm_rd_data;

    dce_skid_buf #(
        .W(8)
    ) u_reply_buf (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_s(tx_if),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    dce_crc16 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .init(r_reg.crc_init),
        .feed(crc_if),
        .crc(crc_val)
    );

    assign rx_ready = r_reg.rx_rdy;
    assign mem_addr = r_reg.addr;
    assign mem_wr_data = r_reg.wr_dat;
    assign pm_rd_en = r_reg.pm_rd_en;
    assign pm_wr_en = r_reg.pm_wr_en;
    assign dm_rd_en = r_reg.dm_rd_en;
    assign dm_wr_en = r_reg.dm_wr_en;
    assign rf_rd_en = r_reg.rf_rd_en;
    assign cpu_debug_halt = r_reg.ctl[CTL_DBG_BIT];
    assign breakpoint_enable = r_reg.ctl[CTL_BPEN_BIT];
    assign sys_reset_req = r_reg.ctl[CTL_RST_BIT];
    assign step_req = r_reg.step_req;
    assign stuff_req = r_reg.stuff_req;
    assign exec_valid = r_reg.exec_vld;
    assign exec_first = r_reg.exec_first;
    assign exec_byte = r_reg.exec_dat;

endmodule : dce_engine

//--- verif/dce_engine_asserts.sv
// Purpose: port checks of the command engine
// Assumes: one clock, async low reset
// Notes: bound to the engine below
`timescale 1ns/10ps
module dce_engine_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // engine outputs
    input wire logic tx_valid,
    input wire dce_pkg::dce_byte_t tx_data,
    input wire logic pm_rd_en,
    input wire logic pm_wr_en,
    input wire logic dm_wr_en,
    input wire logic rf_rd_en,
    input wire logic exec_valid,
    input wire logic cpu_debug_halt,
    input wire logic breakpoint_enable,
    // engine inputs
    input wire logic tx_ready,
    input wire logic flash_unlocked,
    input wire logic read_protect_option,
    input wire logic bp_decoded
);
    import dce_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic open_w = cpu_debug_halt && !read_protect_option;
    AST_PM_WR: assert property (pm_wr_en |-> open_w && flash_unlocked) else $error("pm write");
    AST_DM_WR: assert property (dm_wr_en |-> open_w) else $error("dm write");
    AST_PM_RD: assert property (pm_rd_en |-> cpu_debug_halt) else $error("pm read");
    AST_RF_RD: assert property (rf_rd_en |-> open_w) else $error("reg read");
    AST_EXEC: assert property (exec_valid |-> open_w) else $error("exec");
    AST_BP: assert property (bp_decoded && breakpoint_enable |=> cpu_debug_halt) else $error("bp");
    AST_LOCK: assert property (cpu_debug_halt && read_protect_option |=> cpu_debug_halt) else $error("lock");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("hold");
    cover property (pm_wr_en);
    cover property (bp_decoded && breakpoint_enable);
    cover property (tx_valid && !tx_ready);
endmodule : dce_engine_asserts
bind dce_engine dce_engine_asserts i_dce_engine_asserts (.*);

//--- verif/dce_mem_model.sv
// Purpose: memory and cpu stand-in beside the engine
// Assumes: sync read, data one cycle after enable
// Notes: idle read data toggles so stale bytes never pass
`timescale 1ns/10ps
module dce_mem_model (
    // clock
    input wire logic clk,
    // memory and cpu side
    input wire dce_pkg::dce_addr_t mem_addr,
    input wire dce_pkg::dce_byte_t mem_wr_data,
    input wire logic pm_rd_en,
    input wire logic pm_wr_en,
    input wire logic dm_rd_en,
    input wire logic dm_wr_en,
    input wire logic rf_rd_en,
    output dce_pkg::dce_byte_t pm_rd_data,
    output dce_pkg::dce_byte_t dm_rd_data,
    output dce_pkg::dce_byte_t rf_rd_data,
    output logic [2:0] exec_len
);
    import dce_pkg::*;
    dce_byte_t mem [16];
    initial foreach (mem[i]) mem[i] = 8'h3C ^ 8'(i);
    assign exec_len = 3'h2;
    always @(posedge clk) begin
        pm_rd_data <= pm_rd_en ? mem[mem_addr[3:0]] : ~pm_rd_data;
        dm_rd_data <= dm_rd_en ? mem[mem_addr[3:0]] : ~dm_rd_data;
        rf_rd_data <= rf_rd_en ? ~mem_addr[7:0] : ~rf_rd_data;
        if (pm_wr_en || dm_wr_en) mem[mem_addr[3:0]] <= mem_wr_data;
    end
endmodule : dce_mem_model

//--- verif/test_debug_command_engine.sv
// Purpose: self-checking bench of the command engine
// Assumes: 25 MHz clock, inputs change on falling edge
// Notes: memory cut to 16 bytes; replies stall until read
`timescale 1ns/10ps
module test_debug_command_engine;
    import dce_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, rx_valid = 0, tx_ready = 0, flash_unlocked = 0;
    logic read_protect_option = 0, cpu_halt_mode = 1, bp_decoded = 0, sys_reset_done = 0;
    logic rx_ready, tx_valid, pm_rd_en, pm_wr_en, dm_rd_en, dm_wr_en, rf_rd_en, cpu_debug_halt;
    logic breakpoint_enable, sys_reset_req, step_req, stuff_req, exec_valid, exec_first;
    dce_byte_t rx_data = 8'h00, tx_data, mem_wr_data, pm_rd_data, dm_rd_data, rf_rd_data, exec_byte;
    dce_addr_t mem_addr;
    logic [2:0] exec_len;
    int bad_count = 0, tests_run = 0;
    logic [15:0] pulses = 16'h0000;
    dce_byte_t last_op = 8'h00;
    wire logic [15:0] ctl_pins = {13'h0000, cpu_debug_halt, breakpoint_enable, sys_reset_req};
    always #20 clk = ~clk;
    dce_engine #(.PMEM_BYTES(16)) i_dce_engine (.*);
    dce_mem_model i_dce_mem_model (.*);
    // one nibble per kind: step, stuff, execute pulses
    always @(negedge clk) begin
        pulses <= pulses + {4'h0, 3'h0, exec_valid, 3'h0, stuff_req, 3'h0, step_req};
        if (exec_valid === 1'b1) last_op <= exec_byte;
    end
    task automatic snd(input dce_byte_t q[]);
        foreach (q[i]) begin
            @(negedge clk);
            rx_valid = 1;
            rx_data = q[i];
            while (rx_ready !== 1) @(negedge clk);
            @(negedge clk);
            rx_valid = 0;
        end
    endtask : snd
    task automatic rcv(input dce_byte_t exp);
        @(negedge clk);
        tx_ready = 1;
        while (tx_valid !== 1) @(negedge clk);
        tests_run++;
        if (tx_data !== exp) begin
            bad_count++;
            $display("CHECK FAILED tx_data expected %h seen %h", exp, tx_data);
        end
        @(negedge clk);
        tx_ready = 0;
    endtask : rcv
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [15:0] ref_crc();
        logic [15:0] c;
        c = CRC_INIT;
        for (int a = 0; a < 16; a++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ i_dce_mem_model.mem[a][b]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction : ref_crc
    task automatic t_off;
        bp_decoded = 1;
        @(negedge clk);
        bp_decoded = 0;
        snd('{CMD_RD_PM, 8'h00, 8'h03, 8'h00, 8'h01});
        rcv(FILL_BYTE);
        snd('{CMD_STEP, CMD_EXEC, 8'hAB, CMD_CRC});
        rcv(8'hFF);
        rcv(8'hFF);
        snd('{CMD_RD_STAT});
        rcv(8'h60);
        snd('{CMD_WR_CTL, 8'hFF, CMD_RD_CTL});
        rcv(8'hE1);
        chk("ctl pins", 16'h0007, ctl_pins);
        sys_reset_done = 1;
        @(negedge clk);
        sys_reset_done = 0;
        snd('{CMD_RD_CTL});
        rcv(8'hE0);
        $display("t_off done");
    endtask : t_off
    task automatic t_dbg;
        logic [15:0] crc_exp;
        snd('{CMD_WR_DM, 8'h00, 8'h02, 8'h00, 8'h02, 8'hA5, 8'h5A, CMD_RD_DM, 8'h00, 8'h02, 8'h00, 8'h02});
        rcv(8'hA5);
        rcv(8'h5A);
        flash_unlocked = 1;
        snd('{CMD_WR_PM, 8'h00, 8'h07, 8'h00, 8'h01, 8'h99, CMD_RD_REG, 8'h01, 8'h23, 8'h01});
        rcv(8'hDC);
        snd('{CMD_STEP, CMD_STUFF, 8'h00, CMD_EXEC, 8'hAB, 8'hCD, CMD_RD_PM, 8'h00, 8'h06, 8'h00, 8'h02});
        rcv(8'h3A);
        rcv(8'h99);
        chk("pulses", 16'h0211, pulses);
        chk("exec byte", 16'h00CD, {8'h00, last_op});
        snd('{CMD_CRC});
        crc_exp = ref_crc();
        rcv(crc_exp[15:8]);
        rcv(crc_exp[7:0]);
        $display("t_dbg done");
    endtask : t_dbg
    task automatic t_bp;
        snd('{CMD_WR_CTL, 8'h60, CMD_RD_CTL});
        rcv(8'h60);
        bp_decoded = 1;
        @(negedge clk);
        bp_decoded = 0;
        rcv(ACK_BYTE);
        read_protect_option = 1;
        cpu_halt_mode = 0;
        snd('{CMD_WR_CTL, 8'h00, CMD_RD_CTL});
        rcv(8'h80);
        chk("ctl pins", 16'h0004, ctl_pins);
        snd('{CMD_WR_PM, 8'h00, 8'h07, 8'h00, 8'h01, 8'h11, CMD_EXEC, 8'hAB, CMD_STEP, CMD_STUFF, 8'h00,
            CMD_RD_DM, 8'h00, 8'h02, 8'h00, 8'h01, CMD_RD_STAT});
        rcv(8'hA5);
        rcv(8'h80);
        chk("pulses", 16'h0211, pulses);
        read_protect_option = 0;
        snd('{CMD_RD_PM, 8'h00, 8'h07, 8'h00, 8'h01});
        rcv(8'h99);
        snd('{CMD_WR_CTL, 8'h41, CMD_RD_CTL});
        rcv(8'h41);
        chk("ctl pins", 16'h0003, ctl_pins);
        $display("t_bp done");
    endtask : t_bp
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        t_off;
        t_dbg;
        t_bp;
        tally_and_finish;
    end
    // about twenty times the expected run
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
endmodule : test_debug_command_engine
